/* ipr_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: Shared constants for the interrupt priority resolver.
// Assumes: Source indices follow the fixed service ranking, index 0 highest.
// Notes:   Indices 0 to 5 are the nonmaskable level-3 sources.
//------------------------------------------------------------------------------
package ipr_pkg;

  // ---------------------------------------------------------------------------
  // Source counts and widths.
  // ---------------------------------------------------------------------------
  localparam int NUM_NMI     = 6;
  localparam int NUM_MASK    = 36;
  localparam int NUM_SRC     = NUM_NMI + NUM_MASK;
  localparam int IDX_W       = 6;
  localparam int LVL_W       = 2;
  localparam int NUM_EXT     = 4;

  // ---------------------------------------------------------------------------
  // Priority levels and reset values.
  // ---------------------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_TOP      = 2'h3;
  localparam logic [LVL_W-1:0] LVL_MASK_MAX = 2'h2;
  localparam logic [LVL_W-1:0] LVL_RESET    = 2'h0;
  localparam logic [IDX_W-1:0] IDX_RESET    = 6'h00;

  // ---------------------------------------------------------------------------
  // Ranked source indices, highest first.
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] SRC_HW_RESET    = 6'h00;
  localparam logic [IDX_W-1:0] SRC_STACK_ERR   = 6'h01;
  localparam logic [IDX_W-1:0] SRC_ILLEGAL     = 6'h02;
  localparam logic [IDX_W-1:0] SRC_DEBUG       = 6'h03;
  localparam logic [IDX_W-1:0] SRC_TRAP        = 6'h04;
  localparam logic [IDX_W-1:0] SRC_NMI_LINE    = 6'h05;
  localparam logic [IDX_W-1:0] SRC_EXT_A       = 6'h06;
  localparam logic [IDX_W-1:0] SRC_DMA0        = 6'h0a;
  localparam logic [IDX_W-1:0] SRC_HOST_CMD    = 6'h10;
  localparam logic [IDX_W-1:0] SRC_SSP0_RXE    = 6'h13;
  localparam logic [IDX_W-1:0] SRC_SSP1_RXE    = 6'h19;
  localparam logic [IDX_W-1:0] SRC_ASYNC_RXE   = 6'h1f;
  localparam logic [IDX_W-1:0] SRC_TMR0_OVF    = 6'h24;
  localparam logic [IDX_W-1:0] SRC_LAST        = 6'h29;

endpackage

/* ipr_resolver.sv */
//------------------------------------------------------------------------------
// Purpose: Picks the pending interrupt source that the core services next.
// Assumes: All inputs are synchronous to i_mclk; one boundary pulse per
//          instruction; maskable sources arrive already in ranked order.
// Notes:   Rules carried by this block are listed below.
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module ipr_resolver (
  // Clock, reset and enable.
  input  wire logic                                    i_mclk,
  input  wire logic                                    i_rst,
  input  wire logic                                    i_ce,
  // Nonmaskable level-3 sources, bit 0 hardware reset to bit 5 nmi line.
  input  wire logic [ipr_pkg::NUM_NMI-1:0]             i_nmi_request,
  // External request pins, active low, with per-line trigger mode.
  input  wire logic [ipr_pkg::NUM_EXT-1:0]             i_external_request_n,
  input  wire logic [ipr_pkg::NUM_EXT-1:0]             i_trigger_mode_bit,
  // Other maskable sources in ranked order, DMA channel 0 first.
  input  wire logic [ipr_pkg::NUM_MASK-ipr_pkg::NUM_EXT-1:0] i_periph_request,
  // Per maskable source enable and priority level.
  input  wire logic [ipr_pkg::NUM_MASK-1:0]            i_src_enable,
  input  wire logic [ipr_pkg::NUM_MASK*ipr_pkg::LVL_W-1:0] i_src_level,
  // Status register mask bits.
  input  wire logic [ipr_pkg::LVL_W-1:0]               i_mask,
  // Core handshake.
  input  wire logic                                    i_boundary,
  input  wire logic                                    i_ack,
  // Selected winner.
  output logic                                         o_valid,
  output logic [ipr_pkg::IDX_W-1:0]                    o_source,
  output logic [ipr_pkg::LVL_W-1:0]                    o_priority_level
);

  //----------------------------------------------------------------------------
  // External line sampling.
  //----------------------------------------------------------------------------
  logic [ipr_pkg::NUM_EXT-1:0] ext_prev_n;
  logic [ipr_pkg::NUM_EXT-1:0] ext_edge_latch;
  logic [ipr_pkg::NUM_EXT-1:0] ext_fall;
  logic [ipr_pkg::NUM_EXT-1:0] ext_clear;
  logic [ipr_pkg::NUM_EXT-1:0] ext_pending;

  assign ext_fall = ext_prev_n & ~i_external_request_n;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_prev_n <= 4'hf;
    end else if (i_ce) begin
      ext_prev_n <= i_external_request_n;
    end
  end

  // Acknowledging an edge-mode winner consumes its latched edge.
  always_comb begin
    for (int e = 0; e < ipr_pkg::NUM_EXT; e++) begin
      ext_clear[e] = i_ack && o_valid &&
                     (o_source == ipr_pkg::IDX_W'(ipr_pkg::SRC_EXT_A + ipr_pkg::IDX_W'(e)));
    end
  end

  // A new falling edge in the clearing cycle survives the clear.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_edge_latch <= 4'h0;
    end else if (i_ce) begin
      ext_edge_latch <= (ext_edge_latch & ~ext_clear) | (ext_fall & i_trigger_mode_bit);
    end
  end

  always_comb begin
    for (int e = 0; e < ipr_pkg::NUM_EXT; e++) begin
      ext_pending[e] = i_trigger_mode_bit[e] ? ext_edge_latch[e] : ~i_external_request_n[e];
    end
  end

  //----------------------------------------------------------------------------
  // Candidate table in ranked order.
  //----------------------------------------------------------------------------
  logic [ipr_pkg::NUM_SRC-1:0]   cand_pending;
  logic [ipr_pkg::LVL_W-1:0]     cand_level [ipr_pkg::NUM_SRC];
  logic [ipr_pkg::LVL_W-1:0]     mlvl;

  always_comb begin
    for (int n = 0; n < ipr_pkg::NUM_NMI; n++) begin
      cand_pending[n] = i_nmi_request[n];
      cand_level[n]   = ipr_pkg::LVL_TOP;
    end
    for (int m = 0; m < ipr_pkg::NUM_MASK; m++) begin
      mlvl = i_src_level[m*ipr_pkg::LVL_W +: ipr_pkg::LVL_W];
      cand_level[ipr_pkg::NUM_NMI+m] = mlvl;
      // External lines lead, then DMA, host, sync ports, async port, timers.
      cand_pending[ipr_pkg::NUM_NMI+m] = i_src_enable[m] && (mlvl <= ipr_pkg::LVL_MASK_MAX) &&
        ((m < ipr_pkg::NUM_EXT) ? ext_pending[m] : i_periph_request[m-ipr_pkg::NUM_EXT]);
    end
  end

  //----------------------------------------------------------------------------
  // Resolution.
  //----------------------------------------------------------------------------
  logic                          next_valid;
  logic [ipr_pkg::IDX_W-1:0]     next_source;
  logic [ipr_pkg::LVL_W-1:0]     next_level;

  // Scanning from lowest rank upward, a tie lets the higher rank replace.
  always_comb begin
    next_valid  = 1'b0;
    next_source = ipr_pkg::IDX_RESET;
    next_level  = ipr_pkg::LVL_RESET;
    for (int s = ipr_pkg::NUM_SRC-1; s >= 0; s--) begin
      if (cand_pending[s] && (cand_level[s] >= i_mask)) begin
        if (!next_valid || (cand_level[s] >= next_level)) begin
          next_valid  = 1'b1;
          next_source = ipr_pkg::IDX_W'(s);
          next_level  = cand_level[s];
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // Winner register, loaded at each instruction boundary; an acknowledge between boundaries clears valid.
  //----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_valid          <= 1'b0;
      o_source         <= ipr_pkg::IDX_RESET;
      o_priority_level <= ipr_pkg::LVL_RESET;
    end else if (i_ce) begin
      if (i_boundary) begin
        o_valid          <= next_valid;
        o_source         <= next_source;
        o_priority_level <= next_level;
      end else if (i_ack) begin
        o_valid          <= 1'b0;
      end
    end
  end

endmodule

/* ipr_resolver_props.sv */
// Purpose: Timing and ranking checks on the resolver ports.
// Assumes: Outputs update one edge after a boundary or acknowledge.
// Notes:   Attached by bind below.
`timescale 1ns/100ps
module ipr_resolver_props (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_ce,
  input wire logic [5:0] i_nmi_request,
  input wire logic [1:0] i_mask,
  input wire logic       i_boundary,
  input wire logic       i_ack,
  input wire logic       o_valid,
  input wire logic [5:0] o_source,
  input wire logic [1:0] o_priority_level
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_ack; i_ce && i_ack && !i_boundary |=> !o_valid; endproperty
  a_ack: assert property (p_ack) else $error("ack left winner valid");
  property p_top; i_ce && i_boundary && i_nmi_request[0] |=> o_source == 6'h00 && o_priority_level == 2'h3; endproperty
  a_top: assert property (p_top) else $error("top source lost");
  property p_l3; i_ce && i_boundary && |i_nmi_request |=> o_valid && o_source < 6'h06; endproperty
  a_l3: assert property (p_l3) else $error("level 3 request lost");
  property p_nores; o_valid |-> o_source <= 6'h29; endproperty
  a_nores: assert property (p_nores) else $error("absent source chosen");
  property p_freeze; !i_ce |=> $stable(o_source) && $stable(o_valid); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while disabled");
  property p_hold; i_ce && !i_boundary && !i_ack |=> $stable(o_source); endproperty
  a_hold: assert property (p_hold) else $error("winner moved without boundary");
  property p_mask; i_ce && i_boundary |=> !o_valid || o_priority_level >= $past(i_mask); endproperty
  a_mask: assert property (p_mask) else $error("masked level won");
  property p_none; i_ce && i_boundary && i_nmi_request == 6'h00 && i_mask == 2'h3 |=> !o_valid; endproperty
  a_none: assert property (p_none) else $error("masked request won");
endmodule
bind ipr_resolver ipr_resolver_props u_props (.i_mclk, .i_rst, .i_ce, .i_nmi_request, .i_mask, .i_boundary,
  .i_ack, .o_valid, .o_source, .o_priority_level);

/* ipr_periph_model.sv */
// Purpose: Peripheral sources that hold a request until serviced.
// Assumes: Winner index 10 and up is peripheral index plus 10.
// Notes:   A pulse on i_set raises requests.
`timescale 1ns/100ps
module ipr_periph_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_ack,
  input  wire logic [5:0]  i_source,
  input  wire logic [31:0] i_set,
  output logic      [31:0] o_periph_request
);
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst) o_periph_request <= 32'h0000_0000;
    else if (i_ack && i_source >= 6'h0a) o_periph_request <= (o_periph_request | i_set) & ~(32'h0000_0001 << (i_source - 6'h0a));
    else o_periph_request <= o_periph_request | i_set;
endmodule

/* ipr_resolver_bench.sv */
// Purpose: Self-checking bench for the interrupt priority resolver.
// Assumes: Inputs change on the falling edge.
// Notes:   Peripheral requests come from the source model.
`timescale 1ns/100ps
module ipr_resolver_bench;
  logic i_mclk = 0, i_rst = 1, i_ce = 1, i_boundary = 0, i_ack = 0, o_valid;
  logic [5:0]  i_nmi_request = '0, o_source;
  logic [3:0]  ext_n = 4'hf, trig = 4'h0;
  logic [31:0] raise = '0, periph;
  logic [35:0] en = '1;
  logic [71:0] lvl = {36{2'h1}};
  logic [1:0]  mask = 2'h0, o_priority_level;
  int fails = 0, total_checks = 0, cyc = 0;
  ipr_resolver u_dut (.i_mclk, .i_rst, .i_ce, .i_nmi_request, .i_external_request_n(ext_n), .i_trigger_mode_bit(trig),
    .i_periph_request(periph), .i_src_enable(en), .i_src_level(lvl), .i_mask(mask), .i_boundary, .i_ack, .o_valid,
    .o_source, .o_priority_level);
  ipr_periph_model u_src (.i_mclk, .i_rst, .i_ack, .i_source(o_source), .i_set(raise), .o_periph_request(periph));
  initial forever #20 i_mclk = ~i_mclk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(string what, logic [5:0] got, logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic step(logic b, logic a);
    @(negedge i_mclk) {i_boundary, i_ack} = {b, a};
    @(negedge i_mclk) {i_boundary, i_ack} = 2'h0;
  endtask
  task automatic win(logic [5:0] s, logic [1:0] l);
    step(1'b1, 1'b0);
    chk("valid", {5'h00, o_valid}, 6'h01);
    chk("source", o_source, s);
    chk("level", {4'h0, o_priority_level}, {4'h0, l});
  endtask
  task automatic t_level3;
    for (int k = 0; k < 6; k++) begin
      i_nmi_request = 6'h3f << k;
      win(6'(k), 2'h3);
    end
    i_nmi_request = 6'h00;
    $display("test level3 done");
  endtask
  task automatic t_rank;
    @(negedge i_mclk) raise = '1;
    @(negedge i_mclk) raise = '0;
    for (int k = 0; k < 32; k++) begin
      win(6'(k + 10), 2'h1);
      step(1'b0, 1'b1);
      chk("ack", {5'h00, o_valid}, 6'h00);
    end
    $display("test rank done");
  endtask
  task automatic t_level;
    lvl[71:70] = 2'h2;
    @(negedge i_mclk) raise = 32'h8000_0001;
    @(negedge i_mclk) raise = '0;
    win(6'h29, 2'h2);
    mask = 2'h3;
    step(1'b1, 1'b0);
    chk("masked", {5'h00, o_valid}, 6'h00);
    mask = 2'h2;
    en[35] = 1'b0;
    step(1'b1, 1'b0);
    chk("below", {5'h00, o_valid}, 6'h00);
    mask = 2'h1;
    win(6'h0a, 2'h1);
    $display("test level done");
  endtask
  task automatic t_ext;
    ext_n = 4'h6;
    win(6'h06, 2'h1);
    {ext_n, trig} = {4'hf, 4'h2};
    @(negedge i_mclk) ext_n = 4'hd;
    @(negedge i_mclk) ext_n = 4'hf;
    win(6'h07, 2'h1);
    i_ce = 1'b0;
    step(1'b0, 1'b1);
    chk("frozen", {5'h00, o_valid}, 6'h01);
    i_ce = 1'b1;
    step(1'b0, 1'b1);
    win(6'h0a, 2'h1);
    lvl[1:0] = 2'h3;
    ext_n = 4'he;
    win(6'h0a, 2'h1);
    $display("test ext done");
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) i_rst = 1'b0;
    t_level3();
    t_rank();
    t_level();
    t_ext();
    finish_test();
  end
endmodule
